// *** cbt_params.svh ***
// Constants of the bit timing block: offsets, field positions, reset values, timing.
// Assumes inclusion by bare name from any file that needs them.
`ifndef CBT_PARAMS_SVH
`define CBT_PARAMS_SVH

// ----------------------------------------
// Register byte offsets
// ----------------------------------------
`define CBT_OFS_PRESCALE_JUMP 5'h00
`define CBT_OFS_SEGMENTS_SAMPLING 5'h04
`define CBT_OFS_CONTROL 5'h08
`define CBT_OFS_STATUS 5'h0c
`define CBT_OFS_BIT_PERIOD 5'h10

// ----------------------------------------
// Field positions
// ----------------------------------------
`define CBT_JUMP_MSB 7
`define CBT_JUMP_LSB 6
`define CBT_PRESC_MSB 5
`define CBT_PRESC_LSB 0
`define CBT_TRIPLE_BIT 7
`define CBT_SEG2_MSB 6
`define CBT_SEG2_LSB 4
`define CBT_SEG1_MSB 3
`define CBT_SEG1_LSB 0
`define CBT_CTL_INIT_REQ_BIT 0
`define CBT_CTL_CLK_SEL_BIT 1
`define CBT_STS_INIT_ACK_BIT 0
`define CBT_STS_BIT_VALUE_BIT 1
`define CBT_STS_BAD_CFG_BIT 2

// ----------------------------------------
// Reset values
// ----------------------------------------
`define CBT_RST_PRESCALE_JUMP 8'h00
`define CBT_RST_SEGMENTS_SAMPLING 8'h00
`define CBT_RST_INIT_REQ 1'b1
`define CBT_RST_CLK_SEL 1'b0

// ----------------------------------------
// Timing
// ----------------------------------------
`define CBT_CLK_PERIOD_NS 10
`define CBT_INIT_ACK_DELAY_NS 10
`define CBT_INIT_ACK_CYCLES ((`CBT_INIT_ACK_DELAY_NS + `CBT_CLK_PERIOD_NS - 1) / `CBT_CLK_PERIOD_NS)
`define CBT_SEG1_MIN_CODE 4'h3
`define CBT_SEG1_MIN_TRIPLE_CODE 4'h3

`endif

// *** cbt_pkg.sv ***
// Types shared by the bit timing block.
// Assumes nothing beyond a SystemVerilog compiler.
package cbt_pkg;

  // ----------------------------------------
  // Bit timer phases
  // ----------------------------------------
  typedef enum logic [1:0] {
    CBT_SYNC = 2'b00,
    CBT_SEG1 = 2'b01,
    CBT_SEG2 = 2'b10
  } cbt_phase_type;

endpackage

// *** cbt_timing_if.sv ***
// Interface carrying configuration and bit timing results between block modules.
// Assumes one clock; all signals synchronous to it.
`timescale 1ns/1ps
`default_nettype none
interface cbt_timing_if;
  logic ce;
  logic run;
  logic clk_sel;
  logic osc_tick;
  logic bus_tick;
  logic [5:0] presc;
  logic [1:0] jump;
  logic triple;
  logic [2:0] seg2;
  logic [3:0] seg1;
  logic rx;
  logic tq_tick;
  logic bit_value;
  logic sample_pulse;
  logic bit_start;
  logic resynced;

  modport ctl (output ce, run, clk_sel, osc_tick, bus_tick, presc, jump, triple, seg2, seg1,
    rx, input tq_tick, bit_value, sample_pulse, bit_start, resynced);
  modport qgen (input ce, run, clk_sel, osc_tick, bus_tick, presc, output tq_tick);
  modport btim (input ce, run, jump, triple, seg2, seg1, rx, tq_tick,
    output bit_value, sample_pulse, bit_start, resynced);
endinterface
`default_nettype wire

// *** cbt_quantum_gen.sv ***
// Time quantum generator: selects the module clock tick and divides it.
// Assumes oscillator and bus ticks are one-cycle enables on the system clock.
`timescale 1ns/1ps
`default_nettype none
`include "cbt_params.svh"
module cbt_quantum_gen (
  // Clock and reset
  input wire logic clk,
  input wire logic srst,
  // Configuration and tick
  cbt_timing_if.qgen t
);
  logic [5:0] cnt_q;
  logic tq_q;
  logic src_tick;

  assign src_tick = t.clk_sel ? t.bus_tick : t.osc_tick;
  assign t.tq_tick = tq_q;

  // ----------------------------------------
  // Prescaler
  // ----------------------------------------
  always_ff @(posedge clk) begin
    if (srst) begin
      cnt_q <= 6'h00;
      tq_q <= 1'b0;
    end else if (t.ce) begin
      tq_q <= 1'b0;
      if (!t.run) begin
        cnt_q <= 6'h00;
      end else if (src_tick) begin
        if (cnt_q >= t.presc) begin
          cnt_q <= 6'h00;
          tq_q <= 1'b1;
        end else begin
          cnt_q <= cnt_q + 6'h01;
        end
      end
    end
  end

  AST_TQ_FROM_SOURCE: assert property (@(posedge clk) disable iff (srst)
    ($rose(tq_q) && $past(t.ce)) |-> $past(src_tick))
    else $error("quantum tick without selected module clock tick");

  AST_PRESC_BOUND: assert property (@(posedge clk) disable iff (srst)
    (t.run && $stable(t.presc)) |=> (cnt_q <= t.presc))
    else $error("prescaler count beyond programmed divide");
endmodule
`default_nettype wire

// *** cbt_bit_timer.sv ***
// Bit timer: sync, first and second segment, sampling and resynchronisation.
// Assumes rx is synchronous and the quantum tick is a one-cycle pulse.
`timescale 1ns/1ps
`default_nettype none
`include "cbt_params.svh"
module cbt_bit_timer (
  // Clock and reset
  input wire logic clk,
  input wire logic srst,
  // Configuration and results
  cbt_timing_if.btim t
);
  cbt_pkg::cbt_phase_type phase_q;
  logic [4:0] cnt_q;
  logic [4:0] seg1_lim_q;
  logic [3:0] seg2_lim_q;
  logic [1:0] smp_q;
  logic rx_prev_q;
  logic resync_done_q;
  logic bit_q;
  logic sample_q;
  logic start_q;
  logic resync_q;
  logic edge_seen;
  logic maj;
  logic [4:0] jump_len;
  logic [4:0] seg1_base;
  logic [3:0] seg2_left;

  assign edge_seen = rx_prev_q && !t.rx && !resync_done_q;
  assign maj = (smp_q[1] & smp_q[0]) | (smp_q[1] & t.rx) | (smp_q[0] & t.rx);
  assign jump_len = {3'b000, t.jump} + 5'h01;
  assign seg1_base = {1'b0, t.seg1} + 5'h01;
  assign seg2_left = seg2_lim_q - cnt_q[3:0] - 4'h1;
  assign t.bit_value = bit_q;
  assign t.sample_pulse = sample_q;
  assign t.bit_start = start_q;
  assign t.resynced = resync_q;

  // ----------------------------------------
  // Phase sequencing
  // ----------------------------------------
  always_ff @(posedge clk) begin
    if (srst) begin
      phase_q <= cbt_pkg::CBT_SYNC;
      cnt_q <= 5'h00;
      seg1_lim_q <= 5'h01;
      seg2_lim_q <= 4'h1;
      smp_q <= 2'b11;
      rx_prev_q <= 1'b1;
      resync_done_q <= 1'b0;
      bit_q <= 1'b1;
      sample_q <= 1'b0;
      start_q <= 1'b0;
      resync_q <= 1'b0;
    end else if (t.ce) begin
      sample_q <= 1'b0;
      start_q <= 1'b0;
      resync_q <= 1'b0;
      if (!t.run) begin
        phase_q <= cbt_pkg::CBT_SYNC;
        cnt_q <= 5'h00;
        rx_prev_q <= 1'b1;
        resync_done_q <= 1'b0;
      end else if (t.tq_tick) begin
        rx_prev_q <= t.rx;
        case (phase_q)
          cbt_pkg::CBT_SYNC: begin
            phase_q <= cbt_pkg::CBT_SEG1;
            cnt_q <= 5'h00;
            seg1_lim_q <= seg1_base;
            seg2_lim_q <= {1'b0, t.seg2} + 4'h1;
            resync_done_q <= 1'b0;
            start_q <= 1'b1;
          end
          cbt_pkg::CBT_SEG1: begin
            smp_q <= {smp_q[0], t.rx};
            if (edge_seen) begin
              seg1_lim_q <= seg1_base + ((cnt_q + 5'h01 < jump_len) ? cnt_q + 5'h01 : jump_len);
              resync_done_q <= 1'b1;
              resync_q <= 1'b1;
              cnt_q <= cnt_q + 5'h01;
            end else if (cnt_q + 5'h01 >= seg1_lim_q) begin
              bit_q <= t.triple ? maj : t.rx;
              sample_q <= 1'b1;
              phase_q <= cbt_pkg::CBT_SEG2;
              cnt_q <= 5'h00;
            end else begin
              cnt_q <= cnt_q + 5'h01;
            end
          end
          cbt_pkg::CBT_SEG2: begin
            if (edge_seen && ({1'b0, seg2_left} <= jump_len)) begin
              phase_q <= cbt_pkg::CBT_SEG1;
              cnt_q <= 5'h00;
              seg1_lim_q <= seg1_base;
              seg2_lim_q <= {1'b0, t.seg2} + 4'h1;
              resync_done_q <= 1'b0;
              start_q <= 1'b1;
              resync_q <= 1'b1;
            end else if (edge_seen) begin
              seg2_lim_q <= seg2_lim_q - jump_len[3:0];
              resync_done_q <= 1'b1;
              resync_q <= 1'b1;
              cnt_q <= cnt_q + 5'h01;
            end else if (cnt_q[3:0] + 4'h1 >= seg2_lim_q) begin
              phase_q <= cbt_pkg::CBT_SYNC;
              cnt_q <= 5'h00;
            end else begin
              cnt_q <= cnt_q + 5'h01;
            end
          end
          default: begin
            phase_q <= cbt_pkg::CBT_SYNC;
            cnt_q <= 5'h00;
          end
        endcase
      end
    end
  end

  AST_SYNC_ONE_QUANTUM: assert property (@(posedge clk) disable iff (srst)
    (t.ce && t.run && t.tq_tick && phase_q == cbt_pkg::CBT_SYNC)
      |=> (phase_q == cbt_pkg::CBT_SEG1 && start_q))
    else $error("sync segment did not last one quantum");

  AST_SINGLE_SAMPLE: assert property (@(posedge clk) disable iff (srst)
    (sample_q && !$past(t.triple)) |-> (bit_q == $past(t.rx)))
    else $error("single sample differs from bus level");

  AST_JUMP_BOUND: assert property (@(posedge clk) disable iff (srst)
    (phase_q == cbt_pkg::CBT_SEG1) |-> (seg1_lim_q <= seg1_base + jump_len))
    else $error("first segment lengthened beyond jump width");
endmodule
`default_nettype wire

// *** cbt_top.sv ***
// Top of the CAN bit timing block with an Avalon-MM register slave.
// Assumes all inputs synchronous to CLK; module clock ticks are one-cycle enables.
//
// Summary of operation
// - Jump width field plus one quanta, 1 to 4
// - Prescaler field plus one divides module clock
// - Timing registers writable only in initialization mode
// - Single sample or three-sample majority per bit
// - Second segment field plus one, code zero invalid
// - First segment field plus one, codes 0-2 invalid
// - Bit period is prescale times total quanta
// - Clock select: oscillator zero, bus clock one
//
// Our own choices: the register offsets and register access over Avalon-MM.
`timescale 1ns/1ps
`default_nettype none
`include "cbt_params.svh"
module cbt_top (
  // Clock, reset, enable
  input wire logic CLK,
  input wire logic SRST,
  input wire logic CE,
  // Module clock sources
  input wire logic OSC_TICK,
  input wire logic BUS_TICK,
  // CAN receive line
  input wire logic RXD,
  // Avalon-MM slave
  input wire logic [4:0] AVS_ADDRESS,
  input wire logic AVS_READ,
  input wire logic AVS_WRITE,
  input wire logic [3:0] AVS_BYTEENABLE,
  input wire logic [31:0] AVS_WRITEDATA,
  output logic [31:0] AVS_READDATA,
  output logic AVS_WAITREQUEST,
  // Timing results
  output logic TQ_TICK,
  output logic RX_BIT,
  output logic BIT_SAMPLE,
  output logic BIT_START,
  output logic INIT_ACK
);
  cbt_timing_if t ();

  logic [7:0] prescale_jump_q;
  logic [7:0] segments_sampling_q;
  logic init_req_q;
  logic init_ack_q;
  logic clk_sel_q;
  logic wait_q;
  logic [31:0] rdata_q;
  logic [31:0] rdata_d;
  logic [15:0] period_q;
  logic [15:0] period_d;
  logic [15:0] measured_q;
  logic [15:0] mod_cnt_q;
  logic init_mode;
  logic req;
  logic wr_fire;
  logic wr_lane0;
  logic bad_cfg;
  logic mod_tick;

  // ----------------------------------------
  // Field decode to the timing engine
  // ----------------------------------------
  assign init_mode = init_req_q && init_ack_q;
  assign t.ce = CE;
  assign t.run = !init_ack_q;
  assign t.clk_sel = clk_sel_q;
  assign t.osc_tick = OSC_TICK;
  assign t.bus_tick = BUS_TICK;
  assign t.presc = prescale_jump_q[`CBT_PRESC_MSB:`CBT_PRESC_LSB];
  assign t.jump = prescale_jump_q[`CBT_JUMP_MSB:`CBT_JUMP_LSB];
  assign t.triple = segments_sampling_q[`CBT_TRIPLE_BIT];
  assign t.seg2 = segments_sampling_q[`CBT_SEG2_MSB:`CBT_SEG2_LSB];
  assign t.seg1 = segments_sampling_q[`CBT_SEG1_MSB:`CBT_SEG1_LSB];
  assign t.rx = RXD;
  assign mod_tick = clk_sel_q ? BUS_TICK : OSC_TICK;

  cbt_quantum_gen u_qgen (
    .clk (CLK),
    .srst (SRST),
    .t (t.qgen)
  );

  cbt_bit_timer u_btim (
    .clk (CLK),
    .srst (SRST),
    .t (t.btim)
  );

  // Submodule outputs are flops already
  assign TQ_TICK = t.tq_tick;
  assign RX_BIT = t.bit_value;
  assign BIT_SAMPLE = t.sample_pulse;
  assign BIT_START = t.bit_start;
  assign INIT_ACK = init_ack_q;
  assign AVS_READDATA = rdata_q;
  assign AVS_WAITREQUEST = wait_q;

  // Settings that software must not program; flagged, not corrected
  assign bad_cfg = (t.seg2 == 3'h0)
    || (t.seg1 < `CBT_SEG1_MIN_CODE)
    || (t.triple && t.seg1 < `CBT_SEG1_MIN_TRIPLE_CODE);

  // Nominal bit period in module clock ticks
  assign period_d = 16'({10'h000, t.presc} + 16'h0001)
    * (16'h0003 + {12'h000, t.seg1} + {13'h0000, t.seg2});

  // ----------------------------------------
  // Avalon-MM handshake
  // ----------------------------------------
  // Fixed one wait state keeps read data a plain register
  assign req = AVS_READ || AVS_WRITE;
  assign wr_fire = CE && AVS_WRITE && !wait_q;
  assign wr_lane0 = wr_fire && AVS_BYTEENABLE[0];

  always_ff @(posedge CLK) begin
    if (SRST) begin
      wait_q <= 1'b1;
    end else if (CE) begin
      wait_q <= !(req && wait_q);
    end
  end

  always_comb begin
    rdata_d = 32'h0000_0000;
    case (AVS_ADDRESS)
      `CBT_OFS_PRESCALE_JUMP: begin
        rdata_d[7:0] = prescale_jump_q;
      end
      `CBT_OFS_SEGMENTS_SAMPLING: begin
        rdata_d[7:0] = segments_sampling_q;
      end
      `CBT_OFS_CONTROL: begin
        rdata_d[`CBT_CTL_INIT_REQ_BIT] = init_req_q;
        rdata_d[`CBT_CTL_CLK_SEL_BIT] = clk_sel_q;
      end
      `CBT_OFS_STATUS: begin
        rdata_d[`CBT_STS_INIT_ACK_BIT] = init_ack_q;
        rdata_d[`CBT_STS_BIT_VALUE_BIT] = t.bit_value;
        rdata_d[`CBT_STS_BAD_CFG_BIT] = bad_cfg;
      end
      `CBT_OFS_BIT_PERIOD: begin
        rdata_d = {measured_q, period_q};
      end
      default: begin
        rdata_d = 32'h0000_0000;
      end
    endcase
  end

  always_ff @(posedge CLK) begin
    if (SRST) begin
      rdata_q <= 32'h0000_0000;
    end else if (CE && AVS_READ && wait_q) begin
      rdata_q <= rdata_d;
    end
  end

  // ----------------------------------------
  // Timing registers
  // ----------------------------------------
  always_ff @(posedge CLK) begin
    if (SRST) begin
      prescale_jump_q <= `CBT_RST_PRESCALE_JUMP;
      segments_sampling_q <= `CBT_RST_SEGMENTS_SAMPLING;
    end else if (wr_lane0 && init_mode) begin
      if (AVS_ADDRESS == `CBT_OFS_PRESCALE_JUMP) begin
        prescale_jump_q <= AVS_WRITEDATA[7:0];
      end
      if (AVS_ADDRESS == `CBT_OFS_SEGMENTS_SAMPLING) begin
        segments_sampling_q <= AVS_WRITEDATA[7:0];
      end
    end
  end

  // ----------------------------------------
  // Initialization handshake and clock select
  // ----------------------------------------
  always_ff @(posedge CLK) begin
    if (SRST) begin
      init_req_q <= `CBT_RST_INIT_REQ;
      clk_sel_q <= `CBT_RST_CLK_SEL;
    end else if (wr_lane0 && AVS_ADDRESS == `CBT_OFS_CONTROL) begin
      init_req_q <= AVS_WRITEDATA[`CBT_CTL_INIT_REQ_BIT];
      if (init_mode) begin
        clk_sel_q <= AVS_WRITEDATA[`CBT_CTL_CLK_SEL_BIT];
      end
    end
  end

  // Acknowledge trails the request so timing settles before writes open
  always_ff @(posedge CLK) begin
    if (SRST) begin
      init_ack_q <= `CBT_RST_INIT_REQ;
    end else if (CE) begin
      init_ack_q <= init_req_q;
    end
  end

  // ----------------------------------------
  // Period readback
  // ----------------------------------------
  always_ff @(posedge CLK) begin
    if (SRST) begin
      period_q <= 16'h0000;
    end else if (CE) begin
      period_q <= period_d;
    end
  end

  // Measured ticks between bit starts; resynced bits included as they fall
  always_ff @(posedge CLK) begin
    if (SRST) begin
      mod_cnt_q <= 16'h0000;
      measured_q <= 16'h0000;
    end else if (CE) begin
      if (!t.run) begin
        mod_cnt_q <= 16'h0000;
      end else if (t.bit_start) begin
        measured_q <= mod_cnt_q;
        mod_cnt_q <= {15'h0000, mod_tick};
      end else if (mod_tick) begin
        mod_cnt_q <= mod_cnt_q + 16'h0001;
      end
    end
  end

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  sequence seq_blocked_write;
    wr_lane0 && !init_mode && (AVS_ADDRESS == `CBT_OFS_PRESCALE_JUMP
      || AVS_ADDRESS == `CBT_OFS_SEGMENTS_SAMPLING);
  endsequence

  sequence seq_request_enter;
    CE && !init_req_q ##1 init_req_q && CE;
  endsequence

  AST_TIMING_WRITE_LOCK: assert property (@(posedge CLK) disable iff (SRST)
    seq_blocked_write |=> ($stable(prescale_jump_q) && $stable(segments_sampling_q)))
    else $error("timing register changed outside initialization mode");

  AST_INIT_ACK_FOLLOWS: assert property (@(posedge CLK) disable iff (SRST)
    seq_request_enter |=> (init_ack_q && init_mode))
    else $error("initialization acknowledge did not follow request");

  AST_WAIT_ONE_STATE: assert property (@(posedge CLK) disable iff (SRST)
    (CE && req && wait_q) |=> !wait_q)
    else $error("slave answer did not come after one wait state");

  AST_ENGINE_HALT: assert property (@(posedge CLK) disable iff (SRST)
    init_ack_q |=> !t.bit_start)
    else $error("bit timing ran during initialization mode");

  AST_PERIOD_VALUE: assert property (@(posedge CLK) disable iff (SRST)
    (CE && $stable(prescale_jump_q) && $stable(segments_sampling_q))
      |=> (period_q == ({10'h000, $past(t.presc)} + 16'h0001)
        * (16'h0003 + {12'h000, $past(t.seg1)} + {13'h0000, $past(t.seg2)})))
    else $error("bit period readback wrong");

  // Clock source must not move under a running prescaler
  AST_CLK_SEL_LOCK: assert property (@(posedge CLK) disable iff (SRST)
    (wr_lane0 && !init_mode && AVS_ADDRESS == `CBT_OFS_CONTROL) |=> $stable(clk_sel_q))
    else $error("clock select changed outside initialization mode");

  AST_TIMING_WRITE_LANDS: assert property (@(posedge CLK) disable iff (SRST)
    (wr_lane0 && init_mode && AVS_ADDRESS == `CBT_OFS_SEGMENTS_SAMPLING)
      |=> (segments_sampling_q == $past(AVS_WRITEDATA[7:0])))
    else $error("timing register write in initialization mode lost");
endmodule
`default_nettype wire

// *** cbt_can_node.sv ***
// Remote CAN node model that drives the receive line.
// Assumes start is a one-cycle pulse given while busy is low.
`timescale 1ns/1ps
`default_nettype none
module cbt_can_node (
  // Clock and reset
  input wire logic clk,
  input wire logic srst,
  // Command
  input wire logic start,
  input wire logic [7:0] pattern,
  input wire logic [15:0] bit_cycles,
  // Bus side
  output logic rxd,
  output logic busy
);
  logic [7:0] shift_q;
  logic [3:0] left_q;
  logic [15:0] cnt_q;
  // Recessive when idle: the bus is pulled to 1 when no node drives it
  assign rxd = busy ? shift_q[7] : 1'b1;
  assign busy = (left_q != 4'h0);
  always_ff @(posedge clk) begin
    if (srst) begin
      left_q <= 4'h0;
      shift_q <= 8'hff;
      cnt_q <= 16'h0000;
    end else if (start && !busy) begin
      shift_q <= pattern;
      left_q <= 4'h8;
      cnt_q <= 16'h0000;
    end else if (busy) begin
      if (cnt_q == bit_cycles - 16'h0001) begin
        cnt_q <= 16'h0000;
        shift_q <= {shift_q[6:0], 1'b1};
        left_q <= left_q - 4'h1;
      end else begin
        cnt_q <= cnt_q + 16'h0001;
      end
    end
  end
endmodule
`default_nettype wire

// *** cbt_top_test.sv ***
// Self-checking bench for the bit timing block.
// Assumes the design files and the remote node model are compiled first.
`timescale 1ns/1ps
`default_nettype none
`include "cbt_params.svh"
module cbt_top_test;
  localparam logic [4:0] A_PJ = `CBT_OFS_PRESCALE_JUMP;
  localparam logic [4:0] A_SS = `CBT_OFS_SEGMENTS_SAMPLING;
  localparam logic [4:0] A_CT = `CBT_OFS_CONTROL;
  localparam logic [4:0] A_ST = `CBT_OFS_STATUS;
  localparam logic [4:0] A_BP = `CBT_OFS_BIT_PERIOD;
  logic clk, srst, ce, osc_tick, bus_tick, rxd, rd, wr, wait_rq;
  logic tq, rx_bit, smp, bst, ack, nd_start, nd_busy;
  logic [4:0] addr;
  logic [3:0] be;
  logic [31:0] wdata, rdata;
  logic [7:0] nd_pat, m_pj, m_ss;
  logic [15:0] nd_len;
  logic m_sel, m_req, in_init, tri_s, cs;
  logic [5:0] presc;
  logic [1:0] jump;
  logic [3:0] seg1;
  logic [2:0] seg2;
  int bad_count, n_checks, nom, k, t, base, seed_v;
  int cyc = 0;
  int tq_q[$];
  int bs_q[$];
  int sm_q[$];
  logic rx_q[$];

  cbt_top u_cbt_top (.CLK(clk), .SRST(srst), .CE(ce), .OSC_TICK(osc_tick),
    .BUS_TICK(bus_tick), .RXD(rxd), .AVS_ADDRESS(addr), .AVS_READ(rd), .AVS_WRITE(wr),
    .AVS_BYTEENABLE(be), .AVS_WRITEDATA(wdata), .AVS_READDATA(rdata),
    .AVS_WAITREQUEST(wait_rq), .TQ_TICK(tq), .RX_BIT(rx_bit), .BIT_SAMPLE(smp),
    .BIT_START(bst), .INIT_ACK(ack));
  cbt_can_node u_cbt_can_node (.clk(clk), .srst(srst), .start(nd_start),
    .pattern(nd_pat), .bit_cycles(nd_len), .rxd(rxd), .busy(nd_busy));

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  // Oscillator ticks every other cycle, bus ticks every cycle
  always @(posedge clk) begin
    osc_tick <= ~osc_tick;
    cyc <= cyc + 1;
    if (tq === 1'b1) tq_q.push_back(cyc);
    if (bst === 1'b1) bs_q.push_back(cyc);
    if (smp === 1'b1) begin
      sm_q.push_back(cyc);
      rx_q.push_back(rx_bit);
    end
  end

  // ----------------------------------------
  // Reporting
  // ----------------------------------------
  task automatic stop_test();
    $display("checks %0d errors %0d", n_checks, bad_count);
    if (bad_count == 0 && n_checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  task automatic tally(input logic ok, input string s);
    n_checks++;
    if (ok !== 1'b1) begin
      bad_count++;
      $display("unexpected at %0t: %s", $time, s);
    end
  endtask
  task automatic check_reg(input logic [31:0] g, input logic [31:0] e);
    tally(g === e, $sformatf("reg %h vs %h", g, e));
  endtask
  task automatic check_cnt(input int g, input int e);
    tally(g == e, $sformatf("count %0d vs %0d", g, e));
  endtask
  task automatic check_bit(input logic g, input logic e);
    tally(g === e, $sformatf("bit %b vs %b", g, e));
  endtask

  // ----------------------------------------
  // Avalon master and waits
  // ----------------------------------------
  task automatic bus(input logic w, input logic [4:0] a, input logic [31:0] d,
      output logic [31:0] q);
    int n;
    n = 0;
    rd <= !w;
    wr <= w;
    addr <= a;
    wdata <= d;
    do begin
      @(posedge clk);
      n++;
    end while (wait_rq !== 1'b0 && n < 100);
    q = rdata;
    rd <= 1'b0;
    wr <= 1'b0;
    if (wait_rq !== 1'b0) begin
      tally(1'b0, "bus timeout");
      stop_test();
    end
    @(posedge clk);
  endtask
  task automatic wreg(input logic [4:0] a, input logic [7:0] d, input logic [3:0] b);
    logic [31:0] q;
    be <= b;
    bus(1'b1, a, {24'h00_0000, d}, q);
    if (b[0] && in_init && a == A_PJ) m_pj = d;
    if (b[0] && in_init && a == A_SS) m_ss = d;
    if (b[0] && a == A_CT) begin
      if (in_init) m_sel = d[1];
      m_req = d[0];
    end
  endtask
  task automatic rreg(input logic [4:0] a, input logic [31:0] e, input logic [31:0] mk);
    logic [31:0] q;
    bus(1'b0, a, 32'h0000_0000, q);
    check_reg(q & mk, e & mk);
  endtask
  task automatic rstat();
    logic bad;
    bad = (m_ss[6:4] == 3'h0) || (m_ss[3:0] < 4'h3);
    rreg(A_ST, {29'h0, bad, 1'b0, in_init}, 32'h0000_0005);
  endtask
  task automatic wait_ack(input logic e);
    int n;
    n = 0;
    while (ack !== e && n < 20) begin
      @(posedge clk);
      n++;
    end
    check_bit(ack, e);
    if (ack !== e) stop_test();
    in_init = e;
  endtask
  task automatic wait_ev(input logic smpl, input int cnt);
    int n;
    n = 0;
    while ((smpl ? sm_q.size() : bs_q.size()) < cnt && n < 60000) begin
      @(posedge clk);
      n++;
    end
    if (n >= 60000) begin
      tally(1'b0, "event timeout");
      stop_test();
    end
  endtask

  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    srst = 1'b1;
    ce = 1'b1;
    osc_tick = 1'b0;
    bus_tick = 1'b1;
    rd = 1'b0;
    wr = 1'b0;
    addr = 5'h00;
    be = 4'h1;
    wdata = 32'h0000_0000;
    nd_start = 1'b0;
    nd_pat = 8'h00;
    nd_len = 16'h0001;
    bad_count = 0;
    n_checks = 0;
    m_pj = `CBT_RST_PRESCALE_JUMP;
    m_ss = `CBT_RST_SEGMENTS_SAMPLING;
    m_sel = `CBT_RST_CLK_SEL;
    m_req = `CBT_RST_INIT_REQ;
    in_init = 1'b1;
    seed_v = $urandom(32'hdce9197c);
    repeat (2) @(posedge clk);
    srst <= 1'b0;
    check_bit(ack, 1'b1);
    rstat();
    wreg(5'h14, 8'hff, 4'h1);
    rreg(5'h14, 32'h0000_0000, 32'hffff_ffff);
    wreg(A_PJ, 8'h55, 4'he);
    rreg(A_PJ, {24'h00_0000, m_pj}, 32'hffff_ffff);
    for (int i = 0; i < 5; i++) begin
      presc = (i == 4) ? 6'h3f : 6'($urandom_range(7, 0));
      jump = 2'($urandom_range(3, 0));
      seg1 = 4'($urandom_range(15, 3));
      seg2 = 3'($urandom_range(7, 1));
      tri_s = (presc != 6'h00) && ($urandom_range(1, 0) == 1);
      if (tri_s && seg1 < 4'h4) seg1 = 4'h4;
      cs = i[0];
      wreg(A_CT, {6'h00, cs, 1'b1}, 4'h1);
      wait_ack(1'b1);
      rreg(A_CT, {30'h0, m_sel, m_req}, 32'h0000_0003);
      wreg(A_CT, {6'h00, cs, 1'b1}, 4'h1);
      wreg(A_PJ, {jump, presc}, 4'h1);
      wreg(A_SS, {tri_s, seg2, seg1}, 4'h1);
      rreg(A_PJ, {24'h00_0000, m_pj}, 32'hffff_ffff);
      rreg(A_SS, {24'h00_0000, m_ss}, 32'hffff_ffff);
      nom = (presc + 1) * (3 + seg1 + seg2);
      rreg(A_BP, nom, 32'h0000_ffff);
      rstat();
      wreg(A_CT, {6'h00, cs, 1'b0}, 4'h1);
      wait_ack(1'b0);
      wreg(A_PJ, ~{jump, presc}, 4'h1);
      rreg(A_PJ, {24'h00_0000, m_pj}, 32'hffff_ffff);
      rstat();
      // Timing seen on an idle recessive bus, so no resynchronisation
      tq_q.delete();
      bs_q.delete();
      sm_q.delete();
      rx_q.delete();
      wait_ev(1'b0, 3);
      k = cs ? 1 : 2;
      check_cnt(tq_q[tq_q.size() - 1] - tq_q[tq_q.size() - 2], (presc + 1) * k);
      check_cnt(bs_q[2] - bs_q[1], nom * k);
      t = -1;
      foreach (sm_q[j]) if (t < 0 && sm_q[j] > bs_q[1]) t = sm_q[j];
      check_cnt(t - bs_q[1], (seg1 + 1) * (presc + 1) * k);
      rreg(A_BP, {nom[15:0], nom[15:0]}, 32'hffff_ffff);
      // Remote node sends eight dominant bits at the nominal rate
      nd_len <= 16'(nom * k);
      nd_pat <= 8'h00;
      nd_start <= 1'b1;
      @(posedge clk);
      nd_start <= 1'b0;
      base = sm_q.size();
      wait_ev(1'b1, base + 3);
      check_bit(rx_q[rx_q.size() - 1], 1'b0);
      wait_ev(1'b1, base + 11);
      check_bit(rx_q[rx_q.size() - 1], 1'b1);
    end
    stop_test();
  end
endmodule
`default_nettype wire
